// ### core/sfp_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sfp_buf2 #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic wr_q;
   logic rd_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;
   logic [1:0] cnt_d;

   assign push = i_valid && o_ready;
   assign pop = (cnt_q != 2'h0) && i_ready;
   assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   assign o_valid = (cnt_q != 2'h0);
   assign o_data = mem_q[rd_q];

   // Storage and pointers; ready is a flop so the top port needs no logic
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
         o_ready <= 1'b1;
      end else begin
         if (push) begin
            mem_q[wr_q] <= i_data;
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_d;
         o_ready <= (cnt_d != 2'h2);
      end
   end
endmodule

// ### core/sfp_host.sv
// Host SPI controller issuing program and erase commands to a serial flash
// ====================================================================
// What the document requires
// RULE1: No-erase buffer program uses opcode 88h or 89h plus three bytes.
// RULE2: 528 mode address: two dummy, 12 page bits, ten dummy.
// RULE3: 512 mode address: three dummy, 12 page bits, nine dummy.
// RULE4: Device copies buffer to page on select rise, busy meanwhile.
// RULE5: Host erases the target page before a no-erase program. This block does not; the testbench erases first.
// RULE6: Device checks each byte and sets the error flag on failure.
// RULE7: Load-erase-program uses opcode 82h or 85h.
// RULE8: Through-buffer address: dummies, 12 page bits, 10 or 9 index bits.
// RULE9: Device stores data bytes consecutively in the buffer, wrapping.
// RULE10: Device erases then programs page on select rise, busy meanwhile.
// RULE11: Byte program through buffer one uses opcode 02h, same layout.
// RULE12: Host sends one up to page-size data bytes.
// RULE13: Device writes only received bytes; others keep contents.
// RULE14: Select released only on byte boundaries, else device aborts.
// RULE15: Byte program time scales with byte count, busy throughout.
// RULE16: Binary mode: page and index form one 21-bit byte address.
// RULE17: Page erase uses opcode 81h with the no-erase address layout.
// RULE18: Device erases page to ones on select rise, busy meanwhile.
// RULE19: All bytes go MSB first; early select rise drops the command.
`timescale 1ns/1ps
module sfp_host
   import sfp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd,
   input wire logic i_cmd_buf2,
   input wire logic i_bin_mode,
   input wire logic [11:0] i_page_number,
   input wire logic [9:0] i_buffer_byte_index,
   input wire logic [9:0] i_data_count,
   input wire logic i_data_valid,
   input wire logic [7:0] i_data,
   output logic o_data_ready,
   output logic o_cmd_ready,
   output logic o_done,
   output logic [7:0] o_status,
   output logic o_flash_busy,
   output logic o_program_erase_error_flag,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   input wire logic i_so
);
   import sfp_pkg::*;

   // ====================================================================
   // States
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_OP = 6'b000010,
      ST_ADDR = 6'b000100,
      ST_DATA = 6'b001000,
      ST_STAT = 6'b010000,
      ST_GAP = 6'b100000
   } sfp_state_type;

   sfp_state_type state_q;
   logic [7:0] sh_q;
   logic [2:0] bit_q;
   logic [1:0] byte_q;
   logic [23:0] addr_q;
   logic [2:0] cmd_q;
   logic [9:0] left_q;
   logic [7:0] rx_q;
   logic [1:0] div_q;
   logic tick;
   logic phase_q;
   logic [3:0] gap_q;
   logic so_m_q;
   logic so_s_q;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [9:0] cnt_clip;
   logic [9:0] page_size;
   logic buf_valid;
   logic buf_ready;
   logic [7:0] buf_data;
   logic byte_end;
   logic [7:0] rx_next;

   // Data passes a two-entry buffer so a pause in shifting loses no byte
   sfp_buf2 #(.WIDTH(8)) u_buf (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(i_data_valid),
      .o_ready(o_data_ready),
      .i_data(i_data),
      .o_valid(buf_valid),
      .i_ready(buf_ready),
      .o_data(buf_data)
   );

   // ====================================================================
   // Opcode and address build
   always_comb begin
      case (i_cmd)
         CMD_PROG_NOERASE: opcode = i_cmd_buf2 ? OP_PROG_NOERASE_B2
                                               : OP_PROG_NOERASE_B1; // RULE1
         CMD_LOAD_ERASE_PROG: opcode = i_cmd_buf2 ? OP_LOAD_ERASE_PROG_B2
                                   : OP_LOAD_ERASE_PROG_B1; // RULE7
         CMD_BYTE_PROG: opcode = OP_BYTE_PROG_B1; // RULE11
         CMD_PAGE_ERASE: opcode = OP_PAGE_ERASE; // RULE17
         default: opcode = OP_STATUS_READ;
      endcase
      // Page sits above a 10-bit or 9-bit field; dummy fields send zero
      if (i_bin_mode) begin
         addr = {3'h0, i_page_number, i_buffer_byte_index[8:0]}; // RULE3 RULE16
      end else begin
         addr = {2'h0, i_page_number, i_buffer_byte_index}; // RULE2 RULE8
      end
      if (i_cmd == CMD_PROG_NOERASE || i_cmd == CMD_PAGE_ERASE) begin
         // Index field is don't-care for these; clear it
         addr = i_bin_mode ? {addr[23:9], 9'h000}
                           : {addr[23:10], 10'h000}; // RULE2 RULE3
      end
      page_size = i_bin_mode ? PAGE_SIZE_BIN : PAGE_SIZE_STD;
      // One up to a page of bytes; zero is raised to one
      if (i_data_count == 10'h000) begin
         cnt_clip = 10'h001; // RULE12
      end else if (i_data_count > page_size) begin
         cnt_clip = page_size; // RULE12
      end else begin
         cnt_clip = i_data_count;
      end
   end

   // ====================================================================
   // Serial clock divider: one enable per SCK half period
   always_ff @(posedge i_clk) begin
      if (i_rst || state_q == ST_IDLE || state_q == ST_GAP) begin
         div_q <= 2'h0;
      end else if (div_q == 2'(SCK_DIV - 1)) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end
   assign tick = (div_q == 2'(SCK_DIV - 1));

   // Return line from the flash passes two flops
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         so_m_q <= 1'b0;
         so_s_q <= 1'b0;
      end else begin
         so_m_q <= i_so;
         so_s_q <= so_m_q;
      end
   end

   // Data byte is pulled at the last falling edge of the previous byte;
   // every byte that the sequencer takes must leave the buffer
   assign byte_end = tick && phase_q && bit_q == 3'h7;
   assign buf_ready = byte_end && buf_valid && (left_q != 10'h000) &&
      ((state_q == ST_ADDR && byte_q == 2'(ADDR_BYTES - 1)) ||
       state_q == ST_DATA); // RULE9
   assign rx_next = {rx_q[6:0], so_s_q};

   // ====================================================================
   // Sequencer: mode 0, change SI on falling edge, flash samples on rise
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         o_cs_n <= 1'b1;
         o_sck <= 1'b0;
         o_si <= 1'b0;
         o_cmd_ready <= 1'b1;
         o_done <= 1'b0;
         o_status <= 8'h00;
         o_flash_busy <= 1'b0;
         o_program_erase_error_flag <= 1'b0;
         sh_q <= 8'h00;
         bit_q <= 3'h0;
         byte_q <= 2'h0;
         addr_q <= 24'h000000;
         cmd_q <= CMD_STATUS;
         left_q <= 10'h000;
         rx_q <= 8'h00;
         phase_q <= 1'b0;
         gap_q <= 4'h0;
      end else begin
         o_done <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (i_cmd_valid) begin
                  o_cmd_ready <= 1'b0;
                  o_cs_n <= 1'b0;
                  cmd_q <= i_cmd;
                  addr_q <= addr;
                  left_q <= (i_cmd == CMD_LOAD_ERASE_PROG ||
                             i_cmd == CMD_BYTE_PROG) ? cnt_clip : 10'h000;
                  sh_q <= opcode;
                  o_si <= opcode[7]; // RULE19
                  bit_q <= 3'h0;
                  phase_q <= 1'b0;
                  state_q <= ST_OP;
               end
            end
            ST_OP, ST_ADDR, ST_DATA, ST_STAT: begin
               if (tick) begin
                  phase_q <= ~phase_q;
                  o_sck <= ~phase_q;
                  // Return bit taken at the fall: the two sync flops
                  // need more than one half period to pass it through
                  if (phase_q) begin
                     rx_q <= rx_next;
                  end
                  if (phase_q && bit_q != 3'h7) begin
                     bit_q <= bit_q + 3'h1;
                     sh_q <= {sh_q[6:0], 1'b0};
                     o_si <= sh_q[6]; // RULE19
                  end else if (phase_q) begin
                     bit_q <= 3'h0;
                     // Whole byte sent: select only rises here
                     if (state_q == ST_OP && cmd_q == CMD_STATUS) begin
                        state_q <= ST_STAT;
                        sh_q <= 8'h00;
                        o_si <= 1'b0;
                     end else if (state_q == ST_OP) begin
                        state_q <= ST_ADDR; // RULE19
                        byte_q <= 2'h0;
                        sh_q <= addr_q[23:16];
                        o_si <= addr_q[23];
                        addr_q <= {addr_q[15:0], 8'h00};
                     end else if (state_q == ST_ADDR &&
                                  byte_q != 2'(ADDR_BYTES - 1)) begin
                        byte_q <= byte_q + 2'h1;
                        sh_q <= addr_q[23:16];
                        o_si <= addr_q[23];
                        addr_q <= {addr_q[15:0], 8'h00};
                     end else if (left_q != 10'h000 && buf_valid) begin
                        state_q <= ST_DATA; // RULE9
                        left_q <= left_q - 10'h001;
                        sh_q <= buf_data;
                        o_si <= buf_data[7];
                     end else if (left_q != 10'h000 &&
                                  state_q != ST_DATA) begin
                        // Source stalled: hold clock low, select kept
                        phase_q <= 1'b1;
                        o_sck <= 1'b0;
                        bit_q <= 3'h7;
                     end else if (state_q == ST_DATA && left_q != 10'h000)
                     begin
                        phase_q <= 1'b1;
                        o_sck <= 1'b0;
                        bit_q <= 3'h7;
                     end else begin
                        // Rise on byte boundary starts the flash cycle
                        o_cs_n <= 1'b1; // RULE14
                        o_sck <= 1'b0;
                        if (state_q == ST_STAT) begin
                           o_status <= rx_next;
                           o_flash_busy <= ~rx_next[STAT_RDY_BIT];
                           o_program_erase_error_flag <=
                              rx_next[STAT_EPE_BIT]; // RULE6
                        end else begin
                           o_flash_busy <= 1'b1; // RULE4 RULE10 RULE18
                        end
                        gap_q <= 4'(CS_HIGH_CYC);
                        state_q <= ST_GAP;
                     end
                  end
               end
            end
            ST_GAP: begin
               if (gap_q != 4'h0) begin
                  gap_q <= gap_q - 4'h1;
               end else begin
                  o_done <= 1'b1;
                  o_cmd_ready <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               o_cs_n <= 1'b1;
            end
         endcase
      end
   end
endmodule

// ### core/sfp_pkg.sv
// Package: opcodes, address layout, timing counts for the flash program host
package sfp_pkg;
   // Opcodes
   localparam logic [7:0] OP_PROG_NOERASE_B1 = 8'h88;
   localparam logic [7:0] OP_PROG_NOERASE_B2 = 8'h89;
   localparam logic [7:0] OP_LOAD_ERASE_PROG_B1 = 8'h82;
   localparam logic [7:0] OP_LOAD_ERASE_PROG_B2 = 8'h85;
   localparam logic [7:0] OP_BYTE_PROG_B1 = 8'h02;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   localparam logic [7:0] OP_STATUS_READ = 8'hD7;
   // Command codes on the user port
   localparam logic [2:0] CMD_PROG_NOERASE = 3'h0;
   localparam logic [2:0] CMD_LOAD_ERASE_PROG = 3'h1;
   localparam logic [2:0] CMD_BYTE_PROG = 3'h2;
   localparam logic [2:0] CMD_PAGE_ERASE = 3'h3;
   localparam logic [2:0] CMD_STATUS = 3'h4;
   // Address layout
   localparam int PAGE_BITS = 12;
   localparam int IDX_BITS_STD = 10;
   localparam int IDX_BITS_BIN = 9;
   localparam int ADDR_BITS = 24;
   localparam int ADDR_BYTES = 3;
   // Page sizes
   localparam logic [9:0] PAGE_SIZE_STD = 10'h210;
   localparam logic [9:0] PAGE_SIZE_BIN = 10'h200;
   // Status bit positions
   localparam int STAT_RDY_BIT = 7;
   localparam int STAT_EPE_BIT = 5;
   // Serial clock: 40 MHz / (2*DIV) gives 10 MHz SCK
   localparam int SCK_DIV = 2;
   // Least select-high time in ns and its cycle count (rounded up)
   localparam int CS_HIGH_NS = 50;
   localparam int CLK_NS = 25;
   localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### verification/sfp_flash_model.sv
// Flash device model: frame capture, busy timing, status replies
`timescale 1ns/1ps
module sfp_flash_model (
   input wire logic i_clk,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic i_fail,
   output logic o_so
);
   logic [7:0] sh;
   logic [7:0] stat;
   logic err = 1'b0;
   int bits = 0;
   int cyc = 0;
   int busy_until = 0;
   byte unsigned cur[$];
   byte unsigned last[$];
   // =====
   // Free cycle count; undriven output toggles so it never looks valid
   always @(negedge i_clk) begin
      cyc++;
      if (i_cs_n || bits < 8) begin
         o_so <= (o_so === 1'b1) ? 1'b0 : 1'b1;
      end
   end
   // Shift in MSB first on each rising serial clock
   always @(posedge i_sck) begin
      if (!i_cs_n) begin
         sh = {sh[6:0], i_si};
         bits++;
         if (bits % 8 == 0) begin
            cur.push_back(sh);
         end
      end
   end
   // Status byte out after the opcode: ready in bit 7, error in bit 5
   always @(negedge i_sck) begin
      stat = {cyc >= busy_until, 1'b0, err, 5'h00};
      if (!i_cs_n && bits >= 8) begin
         o_so <= stat[7 - ((bits - 8) % 8)];
      end
   end
   // Start the self-timed operation only for whole, complete frames
   always @(posedge i_cs_n) begin
      if (bits % 8 == 0 && bits >= 32 && cur[0] != 8'hD7) begin
         err = i_fail;
         case (cur[0])
            8'h02: busy_until = cyc + 8 + 4 * (cur.size() - 4);
            8'h81: busy_until = cyc + 60;
            8'h82, 8'h85: busy_until = cyc + 110;
            default: busy_until = cyc + 50;
         endcase
      end
      last = cur;
      cur = {};
      bits = 0;
   end
endmodule

// ### verification/sfp_host_props.sv
// Checker: port timing of the flash program host
`timescale 1ns/1ps
module sfp_host_chk
   import sfp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd,
   input wire logic o_cmd_ready,
   input wire logic o_done,
   input wire logic o_flash_busy,
   input wire logic o_cs_n,
   input wire logic o_sck,
   input wire logic o_si
);
   logic [2:0] bit_q;
   logic [1:0] byte_q;
   logic [2:0] cmd_q;
   // =====
   // Frame counters: bits in byte, bytes seen (saturate at 3)
   always_ff @(posedge i_clk) begin
      if (o_cs_n) begin
         bit_q <= 3'h0;
         byte_q <= 2'h0;
      end else if ($rose(o_sck)) begin
         bit_q <= bit_q + 3'h1;
         if (bit_q == 3'h7 && byte_q != 2'h3) begin
            byte_q <= byte_q + 2'h1;
         end
      end
   end
   // Remember which command is running
   always_ff @(posedge i_clk) begin
      if (i_cmd_valid && o_cmd_ready) begin
         cmd_q <= i_cmd;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence sck_tail;
      o_sck ##1 !o_sck;
   endsequence
   reset_state_a: assert property ($fell(i_rst) |-> o_cs_n && !o_sck
      && o_cmd_ready && !o_done && !o_flash_busy)
      else $error("outputs not at reset state");
   take_select_a: assert property (
      i_cmd_valid && o_cmd_ready |=> !o_cs_n && !o_cmd_ready)
      else $error("select did not follow command");
   done_pulse_a: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   done_idle_a: assert property (o_done |-> o_cmd_ready && o_cs_n)
      else $error("done while not idle");
   sck_idle_a: assert property (o_cs_n |-> !o_sck)
      else $error("serial clock high while deselected");
   si_hold_a: assert property (o_sck |-> $stable(o_si))
      else $error("serial data moved while clock high");
   sck_rate_a: assert property ($rose(o_sck) |=> sck_tail)
      else $error("serial clock high time wrong");
   byte_edge_a: assert property ($rose(o_cs_n) |->
      bit_q == 3'h0 && byte_q >= 2'h2)
      else $error("select released off byte boundary");
   cs_gap_a: assert property ($rose(o_cs_n) |=> o_cs_n [*2])
      else $error("select high time too short");
   prog_busy_a: assert property (
      o_done && cmd_q != CMD_STATUS |-> o_flash_busy)
      else $error("busy not set after program or erase");
endmodule
bind sfp_host sfp_host_chk chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
   .o_done(o_done), .o_flash_busy(o_flash_busy), .o_cs_n(o_cs_n),
   .o_sck(o_sck), .o_si(o_si));

// ### verification/testbench.sv
// Testbench: random program and erase commands against the flash model
`timescale 1ns/1ps
module testbench;
   import sfp_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_cmd_valid = 1'b0;
   logic [2:0] i_cmd = 3'h0;
   logic i_cmd_buf2 = 1'b0;
   logic i_bin_mode = 1'b0;
   logic [11:0] i_page_number = 12'h000;
   logic [9:0] i_buffer_byte_index = 10'h000;
   logic [9:0] i_data_count = 10'h000;
   logic i_data_valid = 1'b0;
   logic [7:0] i_data = 8'h00;
   logic i_fail = 1'b0;
   logic o_data_ready, o_cmd_ready, o_done, o_flash_busy, o_err;
   logic o_cs_n, o_sck, o_si, so;
   logic [7:0] o_status;
   int err_count = 0;
   int tests_run = 0;
   byte unsigned tx[$];
   // 40 MHz clock
   always #12.5 i_clk = ~i_clk;
   sfp_host dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
      .i_cmd(i_cmd), .i_cmd_buf2(i_cmd_buf2), .i_bin_mode(i_bin_mode),
      .i_page_number(i_page_number),
      .i_buffer_byte_index(i_buffer_byte_index),
      .i_data_count(i_data_count), .i_data_valid(i_data_valid),
      .i_data(i_data), .o_data_ready(o_data_ready),
      .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_status(o_status),
      .o_flash_busy(o_flash_busy), .o_program_erase_error_flag(o_err),
      .o_cs_n(o_cs_n), .o_sck(o_sck), .o_si(o_si), .i_so(so));
   sfp_flash_model dev (.i_clk(i_clk), .i_cs_n(o_cs_n), .i_sck(o_sck),
      .i_si(o_si), .i_fail(i_fail), .o_so(so));
   // =====
   // Compare and report
   task automatic check(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Expected opcode and address bytes
   function automatic logic [7:0] exp_op(input logic [2:0] c, input bit b);
      case (c)
         3'h0: return b ? 8'h89 : 8'h88;
         3'h1: return b ? 8'h85 : 8'h82;
         3'h2: return 8'h02;
         default: return 8'h81;
      endcase
   endfunction
   function automatic logic [23:0] exp_adr(input logic [2:0] c,
         input bit bm, input logic [11:0] pg, input logic [9:0] ix);
      logic [9:0] k;
      k = (c == 3'h1 || c == 3'h2) ? ix : 10'h000;
      if (bm) return {3'h0, pg, k[8:0]};
      return {2'h0, pg, k};
   endfunction
   // Feed data words; random gaps of zero to three cycles, too short to let the buffer run dry
   task automatic feed(input int n);
      int k;
      int st;
      for (int j = 0; j < n; j++) begin
         i_data <= tx[j];
         i_data_valid <= 1'b1;
         k = 0;
         do begin
            @(negedge i_clk);
            k++;
         end while (o_data_ready !== 1'b1 && k < 9000);
         if (o_data_ready !== 1'b1) begin
            check(0, "data stalled");
            tally_and_finish;
         end
         @(posedge i_clk);
         st = $urandom_range(0, 3);
         if (st > 0) begin
            i_data_valid <= 1'b0;
            repeat (st) @(posedge i_clk);
         end
      end
      i_data_valid <= 1'b0;
   endtask
   // One command, entered just after a rising edge
   task automatic issue(input logic [2:0] c, input bit b2, input bit bm,
         input logic [11:0] pg, input logic [9:0] ix, input int n, ne);
      int k;
      i_cmd_valid <= 1'b1;
      i_cmd <= c;
      i_cmd_buf2 <= b2;
      i_bin_mode <= bm;
      i_page_number <= pg;
      i_buffer_byte_index <= ix;
      i_data_count <= 10'(n);
      @(posedge i_clk);
      i_cmd_valid <= 1'b0;
      fork
         feed(ne);
         begin
            k = 0;
            while (o_done !== 1'b1) begin
               @(negedge i_clk);
               k++;
               if (k > 30000) begin
                  check(0, "timeout");
                  tally_and_finish;
               end
            end
         end
      join
      @(posedge i_clk);
   endtask
   initial begin
      logic [2:0] c;
      bit b2, bm;
      logic [11:0] pg;
      logic [9:0] ix;
      int n, ne, k, psz;
      bit fl;
      logic [11:0] pe;
      void'($urandom(32'hAE652FD7));
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      check(o_cs_n === 1'b1 && o_cmd_ready === 1'b1, "reset state");
      @(posedge i_clk);
      for (int t = 0; t < 16; t++) begin
         // Erase, program, erase, byte program, load-erase-program
         case (t % 5)
            1: c = CMD_PROG_NOERASE;
            3: c = CMD_BYTE_PROG;
            4: c = CMD_LOAD_ERASE_PROG;
            default: c = CMD_PAGE_ERASE;
         endcase
         b2 = 1'($urandom);
         bm = 1'($urandom);
         pg = 12'($urandom);
         if (c == CMD_PAGE_ERASE) begin
            pe = pg;
         end
         // No-erase commands only target the page erased just before
         if (c == CMD_PROG_NOERASE || c == CMD_BYTE_PROG) begin
            pg = pe;
         end
         ix = (t == 8) ? 10'h3FF : 10'($urandom);
         n = (t == 4) ? 0 : (t == 9) ? 1023 : $urandom_range(1, 6);
         psz = bm ? 512 : 528;
         ne = (n == 0) ? 1 : (n > psz) ? psz : n;
         if (c != CMD_LOAD_ERASE_PROG && c != CMD_BYTE_PROG) begin
            ne = 0;
         end
         tx.delete();
         for (int j = 0; j < ne; j++) tx.push_back(8'($urandom));
         fl = (t % 7 == 3);
         i_fail <= fl;
         issue(c, b2, bm, pg, ix, n, ne);
         check(dev.last.size() == 4 + ne, "frame length");
         check(dev.last[0] == exp_op(c, b2), "opcode");
         check({dev.last[1], dev.last[2], dev.last[3]}
            == exp_adr(c, bm, pg, ix), "address");
         for (int j = 0; j < ne; j++) begin
            check(dev.last[4 + j] == tx[j], "data byte");
         end
         check(o_flash_busy === 1'b1, "busy not set");
         k = 0;
         while (o_flash_busy !== 1'b0 && k < 60) begin
            issue(CMD_STATUS, 0, 0, 12'h000, 10'h000, 0, 0);
            k++;
         end
         check(k > 0 && k < 60, "busy never cleared");
         check(o_err === fl, "error flag");
         check(o_status === {1'b1, 1'b0, fl, 5'h00}, "status");
      end
      tally_and_finish;
   end
endmodule
